// file: src/muldiv_pkg.sv
package muldiv_pkg;

	localparam int WORD_W = 32;
	localparam int HALF_W = 16;
	localparam int PROD_W = 64;
	localparam int IDX_W  = 5;
	localparam int CNT_W  = 6;
	localparam int SKIP_W = 5;

	// divide latency per dividend class, in pipeline clocks
	localparam logic [CNT_W-1:0] DIV_LAT_8  = 6'h0c;
	localparam logic [CNT_W-1:0] DIV_LAT_16 = 6'h13;
	localparam logic [CNT_W-1:0] DIV_LAT_24 = 6'h1a;
	localparam logic [CNT_W-1:0] DIV_LAT_32 = 6'h21;
	localparam logic [CNT_W-1:0] DIV_LAST   = 6'h01;

	// iterations skipped by the early-in check
	localparam logic [SKIP_W-1:0] SKIP_8  = 5'h17;
	localparam logic [SKIP_W-1:0] SKIP_16 = 5'h0f;
	localparam logic [SKIP_W-1:0] SKIP_24 = 5'h07;
	localparam logic [SKIP_W-1:0] SKIP_32 = 5'h00;

	typedef enum logic [3:0] {
		OP_NONE                        = 4'h0,
		OP_PRODUCT_TO_ACC              = 4'h1,
		OP_PRODUCT_TO_ACC_UNSIGNED     = 4'h2,
		OP_PRODUCT_ACCUMULATE          = 4'h3,
		OP_PRODUCT_ACCUMULATE_UNSIGNED = 4'h4,
		OP_PRODUCT_DEDUCT              = 4'h5,
		OP_PRODUCT_DEDUCT_UNSIGNED     = 4'h6,
		OP_PRODUCT_TO_REG              = 4'h7,
		OP_QUOTIENT                    = 4'h8,
		OP_QUOTIENT_UNSIGNED           = 4'h9,
		OP_MOVE_FROM_ACC_HIGH          = 4'ha,
		OP_MOVE_FROM_ACC_LOW           = 4'hb
	} op_t;

	typedef enum logic [1:0] {
		DW_8  = 2'h0,
		DW_16 = 2'h1,
		DW_24 = 2'h2,
		DW_32 = 2'h3
	} dwidth_t;

	typedef struct packed {
		logic              valid;
		op_t               op;
		logic [WORD_W-1:0] first_source_operand;
		logic [WORD_W-1:0] second_source_operand;
		logic [IDX_W-1:0]  dest;
	} issue_t;

	typedef struct packed {
		logic              valid;
		logic [IDX_W-1:0]  idx;
		logic [WORD_W-1:0] data;
	} wb_t;

	function automatic logic op_signed(input op_t op);
		return op inside {OP_PRODUCT_TO_ACC, OP_PRODUCT_ACCUMULATE, OP_PRODUCT_DEDUCT,
			OP_PRODUCT_TO_REG, OP_QUOTIENT};
	endfunction

	function automatic logic op_product_to_acc(input op_t op);
		return op inside {[OP_PRODUCT_TO_ACC:OP_PRODUCT_TO_REG]};
	endfunction

	function automatic logic op_div(input op_t op);
		return op inside {OP_QUOTIENT, OP_QUOTIENT_UNSIGNED};
	endfunction

	function automatic logic fits_half(input logic [WORD_W-1:0] v, input logic sg);
		return sg ? (v[WORD_W-1:HALF_W-1] == {(HALF_W+1){v[HALF_W-1]}})
			: (v[WORD_W-1:HALF_W] == '0);
	endfunction

	function automatic dwidth_t div_class(input logic [WORD_W-1:0] v, input logic sg);
		if (sg ? (v[31:7] == {25{v[7]}}) : (v[31:8] == '0))
			return DW_8;
		if (sg ? (v[31:15] == {17{v[15]}}) : (v[31:16] == '0))
			return DW_16;
		if (sg ? (v[31:23] == {9{v[23]}}) : (v[31:24] == '0))
			return DW_24;
		return DW_32;
	endfunction

	function automatic logic [CNT_W-1:0] div_lat(input dwidth_t c);
		unique case (c)
			DW_8:  return DIV_LAT_8;
			DW_16: return DIV_LAT_16;
			DW_24: return DIV_LAT_24;
			DW_32: return DIV_LAT_32;
		endcase
	endfunction

	function automatic logic [SKIP_W-1:0] div_skip(input dwidth_t c);
		unique case (c)
			DW_8:  return SKIP_8;
			DW_16: return SKIP_16;
			DW_24: return SKIP_24;
			DW_32: return SKIP_32;
		endcase
	endfunction

endpackage

// file: src/div_iter.sv
`timescale 1ns/1ps

module div_iter (
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	// start and operands
	input  wire logic                         start,
	input  wire logic [muldiv_pkg::WORD_W-1:0] dividend,
	input  wire logic [muldiv_pkg::WORD_W-1:0] divisor,
	input  wire logic                         sg,
	input  wire logic [muldiv_pkg::SKIP_W-1:0] skip,
	// results
	output logic      [muldiv_pkg::WORD_W-1:0] quotient,
	output logic      [muldiv_pkg::WORD_W-1:0] remainder
);
	import muldiv_pkg::*;

	typedef struct packed {
		logic [WORD_W:0]   rem;
		logic [WORD_W-1:0] quo;
		logic [WORD_W-1:0] dvs;
		logic [CNT_W-1:0]  iter;
		logic              neg_q;
		logic              neg_r;
	} div_state_t;

	div_state_t r;
	div_state_t next_r;

	always_comb begin
		logic [WORD_W-1:0] mag_a;
		logic [WORD_W-1:0] mag_b;
		logic [WORD_W:0]   shifted;
		logic [WORD_W:0]   diff;
		div_state_t        src;
		mag_a = (sg && dividend[WORD_W-1]) ? WORD_W'(-dividend) : dividend;
		mag_b = (sg && divisor[WORD_W-1]) ? WORD_W'(-divisor) : divisor;
		src = r;
		if (start) begin
			// early-in: the top 23, 15, 7 or 0 sign bits are not iterated [RULE_07]
			src.rem = '0;
			src.quo = mag_a << skip;
			src.dvs = mag_b;
			src.iter = CNT_W'(WORD_W) - CNT_W'(skip);
			src.neg_q = sg && (dividend[WORD_W-1] ^ divisor[WORD_W-1]); // [RULE_17]
			src.neg_r = sg && dividend[WORD_W-1];
		end
		// first step runs in the start clock, else 24 and 32-bit miss their latency
		shifted = {src.rem[WORD_W-1:0], src.quo[WORD_W-1]};
		diff = shifted - {1'b0, src.dvs};
		next_r = src;
		if (src.iter != '0) begin
			// one quotient bit per clock [RULE_06]
			next_r.rem = diff[WORD_W] ? shifted : diff;
			next_r.quo = {src.quo[WORD_W-2:0], ~diff[WORD_W]};
			next_r.iter = src.iter - DIV_LAST;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign quotient = r.neg_q ? WORD_W'(-r.quo) : r.quo;
	assign remainder = r.neg_r ? WORD_W'(-r.rem[WORD_W-1:0]) : r.rem[WORD_W-1:0];

endmodule

// file: src/muldiv_unit.sv
`timescale 1ns/1ps

// Functional notes
// RULE_01 - unit pipeline keeps advancing regardless of integer pipeline stalls
// RULE_02 - multiplier takes full first operand and 16-bit slice of second
// RULE_03 - second operand fitting 16 bits takes one pass, else two passes
// RULE_04 - short multiply issues every clock, full-width only every second clock
// RULE_05 - operand width classified inside the unit from operand values
// RULE_06 - division iterates one quotient bit per clock
// RULE_07 - early-in skips 23, 15 or 7 iterations for 8, 16, 24-bit dividend
// RULE_08 - any unit instruction during a division stalls until it finishes
// RULE_09 - acc-targeted multiplies: latency/repeat 1/1 short, 2/2 full width
// RULE_10 - register-target multiply: latency/repeat 2/1 short, 3/2 full width
// RULE_11 - divide latency/repeat 12/11, 19/18, 26/25, 33/32 by dividend width
// RULE_12 - results land in acc_high/acc_low; moves copy them out
// RULE_13 - register-target multiply sends low product half to destination register
// RULE_14 - accumulate adds product to the 64-bit accumulator pair
// RULE_15 - deduct subtracts product from the 64-bit accumulator pair
// RULE_16 - busy stall shown while divide or second multiply pass pending
// RULE_17 - signedness follows the issued variant for all operations
module muldiv_unit (
	// clock and reset
	input  wire logic                          SYS_CLK,
	input  wire logic                          RST_N,
	// issue from integer pipeline
	input  wire muldiv_pkg::issue_t            ISSUE,
	output logic                               STALL,
	// register write-backs
	output muldiv_pkg::wb_t                    PRODUCT_WB,
	output muldiv_pkg::wb_t                    MOVE_WB,
	// accumulator pair
	output logic      [muldiv_pkg::WORD_W-1:0] ACC_HIGH,
	output logic      [muldiv_pkg::WORD_W-1:0] ACC_LOW
);
	import muldiv_pkg::*;

	typedef struct packed {
		logic [WORD_W-1:0] acc_high;
		logic [WORD_W-1:0] acc_low;
		logic              pass2;
		op_t               p_op;
		logic [WORD_W:0]   p_a;
		logic [HALF_W:0]   p_bh;
		logic [PROD_W-1:0] p_part;
		logic [IDX_W-1:0]  p_dest;
		logic              reg_pend;
		logic [IDX_W-1:0]  reg_idx;
		logic [WORD_W-1:0] reg_data;
		wb_t               product_wb;
		wb_t               move_wb;
		logic              div_busy;
		logic [CNT_W-1:0]  div_cnt;
		logic              stall;
	} mdu_state_t;

	mdu_state_t r;
	mdu_state_t next_r;

	logic              take;
	logic              div_start;
	logic              div_sg;
	logic [SKIP_W-1:0] div_skip_n;
	logic [WORD_W-1:0] div_q;
	logic [WORD_W-1:0] div_r;

	// one 33x17 signed pass through the multiplier array
	function automatic logic [PROD_W-1:0] mul_pass(input logic [WORD_W:0] a,
			input logic [HALF_W:0] b);
		logic signed [WORD_W+HALF_W+1:0] p;
		p = $signed(a) * $signed(b);
		return PROD_W'(p);
	endfunction

	function automatic logic [PROD_W-1:0] acc_apply(input op_t op,
			input logic [PROD_W-1:0] acc, input logic [PROD_W-1:0] prod);
		if (op inside {OP_PRODUCT_ACCUMULATE, OP_PRODUCT_ACCUMULATE_UNSIGNED})
			return acc + prod;
		if (op inside {OP_PRODUCT_DEDUCT, OP_PRODUCT_DEDUCT_UNSIGNED})
			return acc - prod;
		return prod;
	endfunction

	assign take = ISSUE.valid && !r.stall; // [RULE_08]

	always_comb begin
		logic              sg;
		logic [WORD_W:0]   a33;
		logic              fin;
		op_t               fin_op;
		logic [PROD_W-1:0] fin_prod;
		logic [IDX_W-1:0]  fin_dest;
		dwidth_t           dcls;
		sg = op_signed(ISSUE.op); // [RULE_17]
		a33 = {sg & ISSUE.first_source_operand[WORD_W-1], ISSUE.first_source_operand};
		fin = 1'b0;
		fin_op = ISSUE.op;
		fin_prod = '0;
		fin_dest = ISSUE.dest;
		dcls = div_class(ISSUE.first_source_operand, sg); // [RULE_07]
		div_start = 1'b0;
		div_sg = sg;
		div_skip_n = div_skip(dcls);
		next_r = r;
		next_r.product_wb.valid = 1'b0;
		next_r.move_wb.valid = 1'b0;
		// extra stage for the register-target multiply [RULE_10]
		next_r.reg_pend = 1'b0;
		if (r.reg_pend) begin
			next_r.product_wb = '{valid: 1'b1, idx: r.reg_idx, data: r.reg_data};
		end
		// divide runs on regardless of outside stalls [RULE_01]
		// lands first so a multiply taken in its last clock builds on it
		if (r.div_busy) begin
			if (r.div_cnt == DIV_LAST) begin
				next_r.div_busy = 1'b0;
				next_r.acc_high = div_r; // [RULE_12]
				next_r.acc_low = div_q;
			end else begin
				next_r.div_cnt = r.div_cnt - DIV_LAST; // [RULE_11]
			end
		end
		// second pass: upper slice weighted by 2^16 [RULE_03]
		if (r.pass2) begin
			fin = 1'b1;
			fin_op = r.p_op;
			fin_dest = r.p_dest;
			fin_prod = r.p_part + (mul_pass(r.p_a, r.p_bh) << HALF_W);
			next_r.pass2 = 1'b0;
		end else if (take && op_product_to_acc(ISSUE.op)) begin
			// width chosen from the second operand value alone [RULE_02] [RULE_05]
			if (fits_half(ISSUE.second_source_operand, sg)) begin
				fin = 1'b1;
				fin_prod = mul_pass(a33, {sg & ISSUE.second_source_operand[HALF_W-1],
					ISSUE.second_source_operand[HALF_W-1:0]}); // [RULE_03] [RULE_09]
			end else begin
				next_r.pass2 = 1'b1; // [RULE_03]
				next_r.p_op = ISSUE.op;
				next_r.p_a = a33;
				next_r.p_dest = ISSUE.dest;
				next_r.p_bh = {sg & ISSUE.second_source_operand[WORD_W-1],
					ISSUE.second_source_operand[WORD_W-1:HALF_W]};
				next_r.p_part = mul_pass(a33, {1'b0, ISSUE.second_source_operand[HALF_W-1:0]});
			end
		end
		if (fin) begin
			if (fin_op == OP_PRODUCT_TO_REG) begin
				next_r.reg_pend = 1'b1; // [RULE_13]
				next_r.reg_idx = fin_dest;
				next_r.reg_data = fin_prod[WORD_W-1:0];
			end else begin
				// plain, accumulate, deduct into the pair [RULE_12] [RULE_14] [RULE_15]
				{next_r.acc_high, next_r.acc_low} = acc_apply(fin_op,
					{next_r.acc_high, next_r.acc_low}, fin_prod);
			end
		end
		if (take && op_div(ISSUE.op)) begin
			div_start = 1'b1;
			next_r.div_busy = 1'b1;
			next_r.div_cnt = div_lat(dcls) - DIV_LAST; // [RULE_11]
		end
		// moves see a result finishing in the same clock [RULE_12]
		if (take && ISSUE.op inside {OP_MOVE_FROM_ACC_HIGH, OP_MOVE_FROM_ACC_LOW}) begin
			next_r.move_wb = '{valid: 1'b1, idx: ISSUE.dest,
				data: (ISSUE.op == OP_MOVE_FROM_ACC_HIGH) ? next_r.acc_high : next_r.acc_low};
		end
		// busy while second pass or divide pending [RULE_04] [RULE_08] [RULE_16]
		next_r.stall = next_r.pass2 || (next_r.div_busy && next_r.div_cnt != DIV_LAST);
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	div_iter u_div (
		.clk       (SYS_CLK),
		.rst_n     (RST_N),
		.start     (div_start),
		.dividend  (ISSUE.first_source_operand),
		.divisor   (ISSUE.second_source_operand),
		.sg        (div_sg),
		.skip      (div_skip_n),
		.quotient  (div_q),
		.remainder (div_r)
	);

	assign STALL = r.stall;
	assign PRODUCT_WB = r.product_wb;
	assign MOVE_WB = r.move_wb;
	assign ACC_HIGH = r.acc_high;
	assign ACC_LOW = r.acc_low;

	// checks
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	logic short_b;
	logic product_to_acc_acc_u;
	assign short_b = fits_half(ISSUE.second_source_operand, op_signed(ISSUE.op));
	assign product_to_acc_acc_u = take && ISSUE.op == OP_PRODUCT_TO_ACC_UNSIGNED;

	sequence div_hold_s;
		STALL [*8] ##1 STALL ##1 STALL ##1 !STALL;
	endsequence

	short_mul_lat_a: assert property (product_to_acc_acc_u && short_b |=> // [RULE_09]
		{ACC_HIGH, ACC_LOW} == PROD_W'($past(ISSUE.first_source_operand))
			* PROD_W'($past(ISSUE.second_source_operand)) && !STALL)
		else $error("short multiply result or repeat wrong");
	long_mul_lat_a: assert property (product_to_acc_acc_u && !short_b |-> ##1 STALL ##1 // [RULE_09]
		({ACC_HIGH, ACC_LOW} == PROD_W'($past(ISSUE.first_source_operand, 2))
			* PROD_W'($past(ISSUE.second_source_operand, 2))) && !STALL)
		else $error("full-width multiply timing wrong");
	long_interlock_a: assert property (take && op_product_to_acc(ISSUE.op) && !short_b |=> // [RULE_04]
		!take) else $error("back-to-back full-width multiply accepted");
	reg_short_lat_a: assert property (take && ISSUE.op == OP_PRODUCT_TO_REG && short_b // [RULE_10]
		|-> ##1 !PRODUCT_WB.valid ##1 PRODUCT_WB.valid
			&& PRODUCT_WB.idx == $past(ISSUE.dest, 2))
		else $error("register multiply short latency wrong");
	reg_long_lat_a: assert property (take && ISSUE.op == OP_PRODUCT_TO_REG && !short_b // [RULE_10]
		|-> ##1 !PRODUCT_WB.valid ##1 !PRODUCT_WB.valid ##1 PRODUCT_WB.valid)
		else $error("register multiply full latency wrong");
	div_stall_a: assert property (take && op_div(ISSUE.op) // [RULE_08]
		&& div_class(ISSUE.first_source_operand, op_signed(ISSUE.op)) == DW_8
		|=> div_hold_s) else $error("divide stall length wrong");
	div_result_a: assert property (take && ISSUE.op == OP_QUOTIENT_UNSIGNED // [RULE_11]
		&& ISSUE.first_source_operand < 32'h0000_0100 && ISSUE.second_source_operand != '0
		|-> ##12 ACC_LOW == $past(ISSUE.first_source_operand, 12)
			/ $past(ISSUE.second_source_operand, 12))
		else $error("8-bit divide result or latency wrong");
	move_low_a: assert property (take && ISSUE.op == OP_MOVE_FROM_ACC_LOW |=> // [RULE_12]
		MOVE_WB.valid && MOVE_WB.data == ACC_LOW)
		else $error("move from low half wrong");
	accumulate_a: assert property (take && ISSUE.op == OP_PRODUCT_ACCUMULATE_UNSIGNED // [RULE_14]
		&& short_b |=> {ACC_HIGH, ACC_LOW} == $past({ACC_HIGH, ACC_LOW})
			+ PROD_W'($past(ISSUE.first_source_operand))
			* PROD_W'($past(ISSUE.second_source_operand)))
		else $error("accumulate result wrong");

endmodule

// file: test/pipe_model.sv
`timescale 1ns/1ps

module pipe_model (
	// clock
	input  wire logic          clk,
	// unit side
	input  wire logic          stall,
	output muldiv_pkg::issue_t issue
);
	import muldiv_pkg::*;

	initial issue = '0;

	// drive off the falling edge, hold until taken
	task automatic send(input op_t op, input logic [WORD_W-1:0] a, b, input logic [IDX_W-1:0] d);
		@(negedge clk);
		issue = '{valid: 1'b1, op: op, first_source_operand: a,
			second_source_operand: b, dest: d};
		while (stall !== 1'b0) @(negedge clk);
		@(posedge clk);
	endtask

	// released bus shows the inverse of the last operands
	task automatic idle();
		@(negedge clk);
		issue.valid = 1'b0;
		issue.first_source_operand = ~issue.first_source_operand;
		issue.second_source_operand = ~issue.second_source_operand;
	endtask
endmodule

// file: test/muldiv_unit_tb.sv
`timescale 1ns/1ps

module muldiv_unit_tb;
	import muldiv_pkg::*;

	logic              SYS_CLK = 1'b0;
	logic              RST_N   = 1'b0;
	issue_t            ISSUE;
	logic              STALL;
	wb_t               PRODUCT_WB;
	wb_t               MOVE_WB;
	logic [WORD_W-1:0] ACC_HIGH;
	logic [WORD_W-1:0] ACC_LOW;
	int                n_mismatch = 0;
	int                n_checks   = 0;
	int                cyc        = 0;

	always #2.5 SYS_CLK = ~SYS_CLK;

	muldiv_unit i_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .ISSUE(ISSUE), .STALL(STALL),
		.PRODUCT_WB(PRODUCT_WB), .MOVE_WB(MOVE_WB), .ACC_HIGH(ACC_HIGH), .ACC_LOW(ACC_LOW));

	pipe_model i_pipe (.clk(SYS_CLK), .stall(STALL), .issue(ISSUE));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [PROD_W-1:0] got, input logic [PROD_W-1:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [PROD_W-1:0] mul(input logic [WORD_W-1:0] a, b, input logic sg);
		logic [PROD_W-1:0] ea;
		logic [PROD_W-1:0] eb;
		ea = sg ? {{WORD_W{a[WORD_W-1]}}, a} : {32'h0000_0000, a};
		eb = sg ? {{WORD_W{b[WORD_W-1]}}, b} : {32'h0000_0000, b};
		return ea * eb;
	endfunction

	// cycle ceiling
	always @(posedge SYS_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic acc_ops();
		op_t               ops[6] = '{OP_PRODUCT_TO_ACC, OP_PRODUCT_TO_ACC_UNSIGNED,
			OP_PRODUCT_ACCUMULATE, OP_PRODUCT_ACCUMULATE_UNSIGNED,
			OP_PRODUCT_DEDUCT, OP_PRODUCT_DEDUCT_UNSIGNED};
		logic [WORD_W-1:0] bs[2] = '{32'h0000_7abc, 32'h8765_4321};
		logic [PROD_W-1:0] acc = '0;
		logic [PROD_W-1:0] old;
		logic [PROD_W-1:0] p;
		for (int w = 0; w < 2; w++) begin
			for (int i = 0; i < 6; i++) begin
				p = mul(32'hf123_4567, bs[w], (i % 2) == 0);
				old = acc;
				acc = (i < 2) ? p : (i < 4) ? acc + p : acc - p;
				i_pipe.send(ops[i], 32'hf123_4567, bs[w], 5'h00);
				i_pipe.idle();
				if (w == 1) begin
					chk(STALL, 1);
					chk({ACC_HIGH, ACC_LOW}, old);
					@(negedge SYS_CLK);
				end
				chk(STALL, 0);
				chk({ACC_HIGH, ACC_LOW}, acc);
			end
		end
	endtask

	task automatic back_to_back();
		int                t0;
		logic [WORD_W-1:0] b;
		for (int w = 0; w < 2; w++) begin
			b = w ? 32'h1234_5678 : 32'h0000_0005;
			i_pipe.send(OP_PRODUCT_TO_ACC, 32'h0000_0003, b, 5'h00);
			t0 = cyc;
			i_pipe.send(OP_PRODUCT_TO_ACC, 32'h0000_0007, b, 5'h00);
			chk(cyc - t0, w + 1);
			i_pipe.idle();
			if (w == 1)
				@(negedge SYS_CLK);
			chk({ACC_HIGH, ACC_LOW}, mul(32'h0000_0007, b, 1'b1));
		end
	endtask

	task automatic reg_mul();
		logic [WORD_W-1:0] b;
		logic [PROD_W-1:0] p;
		for (int w = 0; w < 2; w++) begin
			b = w ? 32'hfedc_ba98 : 32'hffff_fff3;
			p = mul(32'h8000_0011, b, 1'b1);
			i_pipe.send(OP_PRODUCT_TO_REG, 32'h8000_0011, b, 5'h13);
			i_pipe.idle();
			for (int n = 1; n < 2 + w; n++) begin
				chk(PRODUCT_WB.valid, 0);
				@(negedge SYS_CLK);
			end
			chk(PRODUCT_WB.valid, 1);
			chk(PRODUCT_WB.idx, 5'h13);
			chk(PRODUCT_WB.data, p[WORD_W-1:0]);
		end
	endtask

	task automatic divide();
		logic [WORD_W-1:0] ds[4] = '{32'h0000_0075, 32'h0000_7fff, 32'h0070_0001, 32'h8000_0001};
		int                lat[4] = '{12, 19, 26, 33};
		logic [WORD_W-1:0] a;
		logic [WORD_W-1:0] d;
		logic [WORD_W-1:0] q;
		logic [WORD_W-1:0] r;
		int                t0;
		for (int u = 0; u < 2; u++) begin
			for (int c = 0; c < 4; c++) begin
				a = u ? ds[c] : ~ds[c];
				d = u ? 32'h0000_0007 : 32'hffff_fffd;
				if (u) begin
					q = a / d;
					r = a % d;
				end else begin
					q = $signed(a) / $signed(d);
					r = $signed(a) % $signed(d);
				end
				i_pipe.send(u ? OP_QUOTIENT_UNSIGNED : OP_QUOTIENT, a, d, 5'h00);
				t0 = cyc;
				i_pipe.send(c[0] ? OP_MOVE_FROM_ACC_HIGH : OP_MOVE_FROM_ACC_LOW,
					32'h0000_0000, 32'h0000_0000, 5'h0a);
				chk(cyc - t0, lat[c] - 1);
				i_pipe.idle();
				chk(MOVE_WB.valid, 1);
				chk(MOVE_WB.idx, 5'h0a);
				chk(MOVE_WB.data, c[0] ? r : q);
				chk({ACC_HIGH, ACC_LOW}, {r, q});
			end
		end
	endtask

	task automatic reset_mid_divide();
		i_pipe.send(OP_QUOTIENT, 32'h8000_0001, 32'h0000_0003, 5'h00);
		i_pipe.idle();
		chk(STALL, 1);
		RST_N = 1'b0;
		@(negedge SYS_CLK);
		chk(STALL, 0);
		chk({ACC_HIGH, ACC_LOW}, 64'h0000_0000_0000_0000);
		RST_N = 1'b1;
		i_pipe.send(OP_PRODUCT_TO_ACC_UNSIGNED, 32'h0000_0009, 32'h0000_0006, 5'h00);
		i_pipe.idle();
		chk({ACC_HIGH, ACC_LOW}, mul(32'h0000_0009, 32'h0000_0006, 1'b0));
		chk(STALL, 0);
	endtask

	initial begin
		repeat (20) @(negedge SYS_CLK);
		chk({ACC_HIGH, ACC_LOW}, 64'h0000_0000_0000_0000);
		chk({STALL, PRODUCT_WB.valid, MOVE_WB.valid}, 3'h0);
		RST_N = 1'b1;
		acc_ops();
		back_to_back();
		reg_mul();
		divide();
		reset_mid_divide();
		end_of_test();
	end
endmodule
